// >>> logic/rx_sysif_pkg.sv
// constants, control layout and state carriers of the receive system interface
// assumes a 40 MHz system clock and one line channel per instance
`default_nettype none

package rx_sysif_pkg;

  // ==========================================================================
  // register port
  localparam int              ADDR_W      = 4;
  localparam int              DATA_W      = 16;
  localparam logic [ADDR_W-1:0] CTRL_ADDR   = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h1;
  // status bit positions
  localparam int              STAT_MISS_STICKY = 0;
  localparam int              STAT_MISS_NOW    = 1;
  localparam int              STAT_MCLK_LOST   = 2;
  localparam int              STAT_LOS         = 3;

  // ==========================================================================
  // sampled pins, index into the sampler vector
  localparam int PIN_COUNT    = 7;
  localparam int PIN_MCLK     = 0;
  localparam int PIN_TXCLK    = 1;
  localparam int PIN_RECCLK   = 2;
  localparam int PIN_SLICEPOS = 3;
  localparam int PIN_SLICENEG = 4;
  localparam int PIN_TXPOS    = 5;
  localparam int PIN_TXNEG    = 6;

  // ==========================================================================
  // timing
  localparam int SYS_CLK_PS   = 25000;
  localparam int MCLK_LOSS_NS = 1000;
  // least time, so round up to whole system cycles
  localparam int MCLK_LOSS_CYCLES = (MCLK_LOSS_NS * 1000 + SYS_CLK_PS - 1) / SYS_CLK_PS;
  localparam logic [5:0] MCLK_LOSS_LIMIT      = 6'(MCLK_LOSS_CYCLES);
  localparam logic [6:0] TCK_MISS_MCLK_CYCLES = 7'h46;
  // excess zero run lengths per line code
  localparam logic [4:0] EXZ_AMI  = 5'h10;
  localparam logic [4:0] EXZ_HDB3 = 5'h04;
  localparam logic [4:0] EXZ_B8ZS = 5'h08;
  localparam logic [14:0] LFSR_SEED = 15'h7fff;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    CODE_AMI  = 2'h0,
    CODE_HDB3 = 2'h1,
    CODE_B8ZS = 2'h2
  } line_code_t;

  typedef enum logic [1:0] {
    PAT_NONE  = 2'h0,
    PAT_ONES  = 2'h1,
    PAT_ZEROS = 2'h2,
    PAT_PRBS  = 2'h3
  } pattern_t;

  typedef enum logic [1:0] {
    TCK_RUN  = 2'h1,
    TCK_MISS = 2'h2
  } tck_state_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic       txClkMissMask;
    logic       sendAllOnes;
    logic       automaticAllOnesSend;
    pattern_t   pattern;
    logic       hwMode;
    logic       patternRefMclk;
    logic       alarmIndicationEnable;
    logic       invertData;
    logic       risingLaunch;
    logic       clockDataRecovery;
    line_code_t lineCode;
    logic       singleRail;
  } ctrl_t;

  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h201b;

  typedef struct packed {
    logic [PIN_COUNT-1:0] meta;
    logic [PIN_COUNT-1:0] sync;
    logic [PIN_COUNT-1:0] prev;
  } sampler_state_t;

  typedef struct packed {
    ctrl_t             ctrl;
    logic              stickyMiss;
    tck_state_t        tck;
    logic [6:0]        txCnt;
    logic [5:0]        mclkCnt;
    logic              mclkLost;
    logic [7:0]        winPos;
    logic [7:0]        winNeg;
    logic [7:0]        winViol;
    logic              lastPol;
    logic [4:0]        zeroCnt;
    logic              retPos;
    logic              retNeg;
    logic              rxClockOut;
    logic              rxPositiveRail;
    logic              rxNegativeRail;
    logic [DATA_W-1:0] rdData;
    logic              txLinePos;
    logic              txLineNeg;
    logic              txLineOe;
    logic              onesPol;
    logic [14:0]       lfsr;
    logic              txClockIrq;
  } core_state_t;

endpackage

`default_nettype wire

// >>> logic/pin_sampler.sv
// two-flop synchroniser with edge detection for all foreign pins
// assumes the pins are asynchronous to clk and change slower than clk
`timescale 1ns/1ps
`default_nettype none

module pin_sampler
  import rx_sysif_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic [PIN_COUNT-1:0] pinIn,
  output logic      [PIN_COUNT-1:0] level,
  output logic      [PIN_COUNT-1:0] rise,
  output logic      [PIN_COUNT-1:0] fall
);

  sampler_state_t s_q;
  sampler_state_t s_d;

  // ==========================================================================
  // meta stage feeds only the sync stage
  always_comb begin
    s_d.meta = pinIn;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // edges from the settled stages only
  assign level = s_q.sync;
  assign rise  = s_q.sync & ~s_q.prev;
  assign fall  = ~s_q.sync & s_q.prev;

endmodule // pin_sampler

`default_nettype wire

// >>> logic/rx_system_interface.sv
// receive system interface of one line channel with master clock duties
// assumes losIn comes from logic on clk; every other line pin is foreign
// and is sampled by the 40 MHz clk, so all line clocks must be far slower
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - transmit clock stuck over 70 master cycles: missing
// - unmasked missing transmit clock raises interrupt
// - single rail with recovery: decoded NRZ on positive pin
// - violation pin high one full receive cycle
// - HDB3/B8ZS flag code violations, AMI bipolar
// - hardware single rail also flags excess zeros
// - dual rail with recovery: retimed NRZ rails
// - dual rail bypass: raw slicer rails out
// - launch edge of receive clock is selectable
// - receive data polarity is selectable
// - receive clock rate follows line rate
// - LOS with alarm enable: clock from master
// - recovery mode: recovered clock, data on edge
// - bypass: receive clock is rail XOR
// - master reference times transmit patterns
// - automatic all ones always from master
// - hardware mode patterns use master reference
// - master clock lost: line drivers high impedance
module rx_system_interface
  import rx_sysif_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdData,
  input  wire logic              mclkIn,
  input  wire logic              txClockIn,
  input  wire logic              recClockIn,
  input  wire logic              rxSlicePos,
  input  wire logic              rxSliceNeg,
  input  wire logic              txPosIn,
  input  wire logic              txNegIn,
  input  wire logic              losIn,
  output logic                   rxClockOut,
  output logic                   rxPositiveRail,
  output logic                   rxNegativeRail,
  output logic                   txLinePos,
  output logic                   txLineNeg,
  output logic                   txLineOe,
  output logic                   txClockIrq
);

  // ==========================================================================
  // pin sampling
  logic [PIN_COUNT-1:0] pinLevel;
  logic [PIN_COUNT-1:0] pinRise;
  logic [PIN_COUNT-1:0] pinFall;

  pin_sampler sampler (
    .clk    (clk),
    .resetn (resetn),
    .pinIn  ({txNegIn, txPosIn, rxSliceNeg, rxSlicePos, recClockIn, txClockIn, mclkIn}),
    .level  (pinLevel),
    .rise   (pinRise),
    .fall   (pinFall)
  );

  core_state_t s_q;
  core_state_t s_d;

  // ==========================================================================
  // decoder and transmit helpers, all combinational on the sampled pins, losIn and state
  logic       mclkRise;
  logic       mclkEdge;
  logic       txClkEdge;
  logic       bitStrobe;
  logic       inPos;
  logic       inNeg;
  logic       inPulse;
  logic       isBipolarV;
  logic [4:0] exzLimit;
  logic       aisClock;
  logic       launch;
  logic       rxClockNext;
  logic       forceOnes;
  logic       useMclk;
  logic       refTick;
  logic       patternOn;
  logic       patternBit;

  assign mclkRise   = pinRise[PIN_MCLK];
  assign mclkEdge   = pinRise[PIN_MCLK] | pinFall[PIN_MCLK];
  assign txClkEdge  = pinRise[PIN_TXCLK] | pinFall[PIN_TXCLK];
  // one decoded bit per rising recovered clock edge
  assign bitStrobe  = pinRise[PIN_RECCLK] & s_q.ctrl.clockDataRecovery;
  assign inPos      = pinLevel[PIN_SLICEPOS];
  assign inNeg      = pinLevel[PIN_SLICENEG];
  assign inPulse    = inPos ^ inNeg;
  // a pulse of the same polarity as the last one breaks alternation
  assign isBipolarV = inPulse & (inPos == s_q.lastPol);
  assign exzLimit   = (s_q.ctrl.lineCode == CODE_HDB3) ? EXZ_HDB3 :
                      (s_q.ctrl.lineCode == CODE_B8ZS) ? EXZ_B8ZS : EXZ_AMI;
  assign aisClock   = losIn & s_q.ctrl.alarmIndicationEnable;

  // receive clock source, kept outside the next-state process to avoid a loop
  assign rxClockNext = aisClock ? pinLevel[PIN_MCLK] :
                       s_q.ctrl.clockDataRecovery ? pinLevel[PIN_RECCLK] :
                       (inPos ^ inNeg);
  // the selected edge of our own clock output launches receive data
  assign launch = s_q.ctrl.risingLaunch ? (!s_q.rxClockOut & rxClockNext)
                                        : (s_q.rxClockOut & !rxClockNext);

  // transmit pattern references
  assign forceOnes  = s_q.ctrl.sendAllOnes | (s_q.ctrl.automaticAllOnesSend & losIn);
  assign patternOn  = forceOnes | (s_q.ctrl.pattern != PAT_NONE);
  // automatic all ones ignores the reference select
  assign useMclk    = s_q.ctrl.patternRefMclk | s_q.ctrl.hwMode
                    | (s_q.ctrl.automaticAllOnesSend & losIn);
  assign refTick    = useMclk ? mclkRise : pinRise[PIN_TXCLK];
  assign patternBit = (forceOnes | (s_q.ctrl.pattern == PAT_ONES)) ? 1'b1 :
                      (s_q.ctrl.pattern == PAT_PRBS) ? s_q.lfsr[14] : 1'b0;

  // ==========================================================================
  // next state
  always_comb begin
    logic [7:0] wPos;
    logic [7:0] wNeg;
    logic [7:0] wViol;
    logic [7:0] wPulse;
    logic       excess_zero_error;
    wPos   = '0;
    wNeg   = '0;
    wViol  = '0;
    wPulse = '0;
    excess_zero_error    = 1'b0;
    s_d    = s_q;

    // register writes
    if (regWr && regAddr == CTRL_ADDR) begin
      s_d.ctrl      = ctrl_t'(regWrData);
      s_d.ctrl.rsvd = 2'h0;
    end
    if (regWr && regAddr == STATUS_ADDR && regWrData[STAT_MISS_STICKY]) begin
      s_d.stickyMiss = 1'b0;
    end

    // register reads answer in the next cycle only
    s_d.rdData = '0;
    if (regRd) begin
      unique case (regAddr)
        CTRL_ADDR:   s_d.rdData = DATA_W'(s_q.ctrl);
        STATUS_ADDR: begin
          s_d.rdData[STAT_MISS_STICKY] = s_q.stickyMiss;
          s_d.rdData[STAT_MISS_NOW]    = (s_q.tck == TCK_MISS);
          s_d.rdData[STAT_MCLK_LOST]   = s_q.mclkLost;
          s_d.rdData[STAT_LOS]         = losIn;
        end
        default:     s_d.rdData = '0;
      endcase
    end

    // master clock watchdog on the independent system clock
    if (mclkEdge) begin
      s_d.mclkCnt  = '0;
      s_d.mclkLost = 1'b0;
    end else if (s_q.mclkCnt == MCLK_LOSS_LIMIT - 6'h01) begin
      s_d.mclkLost = 1'b1;
    end else begin
      s_d.mclkCnt = 6'(s_q.mclkCnt + 6'h01);
    end

    // transmit clock monitor counts rising master clock edges between its edges
    if (txClkEdge) begin
      s_d.txCnt = '0;
      s_d.tck   = TCK_RUN;
    end else if (mclkRise) begin
      if (s_q.txCnt == TCK_MISS_MCLK_CYCLES) begin
        s_d.tck = TCK_MISS;
      end else begin
        s_d.txCnt = 7'(s_q.txCnt + 7'h01);
      end
    end
    // setting beats a clear in the same cycle
    if (s_d.tck == TCK_MISS && s_q.tck != TCK_MISS) begin
      s_d.stickyMiss = 1'b1;
    end
    s_d.txClockIrq = s_d.stickyMiss & ~s_d.ctrl.txClkMissMask;

    // line decoder: eight-bit window, oldest bit leaves at index 7
    if (bitStrobe) begin
      excess_zero_error    = !inPulse && s_q.ctrl.hwMode && 5'(s_q.zeroCnt + 5'h01) == exzLimit;
      wPos   = {s_q.winPos[6:0], inPos & inPulse};
      wNeg   = {s_q.winNeg[6:0], inNeg & inPulse};
      // both rails at once is always a violation
      wViol  = {s_q.winViol[6:0], isBipolarV | (inPos & inNeg) | excess_zero_error};
      wPulse = wPos | wNeg;
      // zero substitution 000V or B00V is legal and carries zeros
      if (s_q.ctrl.lineCode == CODE_HDB3 && isBipolarV && !wPulse[1] && !wPulse[2]) begin
        wPos[0]  = 1'b0;
        wNeg[0]  = 1'b0;
        wViol[0] = 1'b0;
        wPos[3]  = 1'b0;
        wNeg[3]  = 1'b0;
      end
      // eight zeros sent as 000VB0VB
      if (s_q.ctrl.lineCode == CODE_B8ZS && wPulse[7:5] == 3'h0 && wPulse[4] && wPulse[3]
          && !wPulse[2] && wPulse[1] && wPulse[0] && wPos[0] == wPos[4]
          && wPos[1] == wPos[3] && wPos[0] != wPos[1]) begin
        wPos  = wPos & 8'he4;
        wNeg  = wNeg & 8'he4;
        wViol = wViol & 8'he4;
      end
      s_d.winPos  = wPos;
      s_d.winNeg  = wNeg;
      s_d.winViol = wViol;
      if (inPulse) begin
        s_d.lastPol = inPos;
        s_d.zeroCnt = '0;
      end else if (s_q.zeroCnt != 5'h1f) begin
        s_d.zeroCnt = 5'(s_q.zeroCnt + 5'h01);
      end
      s_d.retPos = inPos;
      s_d.retNeg = inNeg;
    end

    // receive clock source, chosen ahead of the launch decision
    s_d.rxClockOut = rxClockNext;

    // receive data: bypass passes raw rails, else launched on the edge
    if (!s_q.ctrl.clockDataRecovery) begin
      s_d.rxPositiveRail = inPos ^ s_q.ctrl.invertData;
      s_d.rxNegativeRail = inNeg ^ s_q.ctrl.invertData;
    end else if (launch) begin
      if (s_q.ctrl.singleRail) begin
        s_d.rxPositiveRail = (s_q.winPos[7] | s_q.winNeg[7]) ^ s_q.ctrl.invertData;
        // held until the next launch, so one whole receive cycle
        s_d.rxNegativeRail = s_q.winViol[7];
      end else begin
        s_d.rxPositiveRail = s_q.retPos ^ s_q.ctrl.invertData;
        s_d.rxNegativeRail = s_q.retNeg ^ s_q.ctrl.invertData;
      end
    end

    // transmit line: drivers released while the master clock is gone
    if (s_q.mclkLost) begin
      s_d.txLineOe  = 1'b0;
      s_d.txLinePos = 1'b0;
      s_d.txLineNeg = 1'b0;
    end else begin
      s_d.txLineOe = 1'b1;
      if (!patternOn) begin
        s_d.txLinePos = pinLevel[PIN_TXPOS];
        s_d.txLineNeg = pinLevel[PIN_TXNEG];
      end else if (refTick) begin
        // marks alternate so the pattern stays free of violations
        s_d.txLinePos = patternBit & !s_q.onesPol;
        s_d.txLineNeg = patternBit & s_q.onesPol;
        if (patternBit) begin
          s_d.onesPol = !s_q.onesPol;
        end
        if (s_q.ctrl.pattern == PAT_PRBS) begin
          s_d.lfsr = {s_q.lfsr[13:0], s_q.lfsr[14] ^ s_q.lfsr[13]};
        end
      end
    end
  end

  // ==========================================================================
  // state register; master clock counted lost until its first edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q          <= '0;
      s_q.ctrl     <= ctrl_t'(CTRL_RESET);
      s_q.tck      <= TCK_RUN;
      s_q.mclkLost <= 1'b1;
      s_q.lfsr     <= LFSR_SEED;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData      = s_q.rdData;
  assign rxClockOut     = s_q.rxClockOut;
  assign rxPositiveRail = s_q.rxPositiveRail;
  assign rxNegativeRail = s_q.rxNegativeRail;
  assign txLinePos      = s_q.txLinePos;
  assign txLineNeg      = s_q.txLineNeg;
  assign txLineOe       = s_q.txLineOe;
  assign txClockIrq     = s_q.txClockIrq;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  tx_miss_set_a: assert property ($rose(s_q.tck == TCK_MISS) |->
      $past(s_q.txCnt) == TCK_MISS_MCLK_CYCLES && $past(mclkRise))
    else $error("transmit clock missing set at wrong count");

  tx_miss_irq_a: assert property ($rose(s_q.tck == TCK_MISS) && !s_q.ctrl.txClkMissMask
      |-> txClockIrq)
    else $error("missing transmit clock gave no interrupt");

  cv_hold_a: assert property (s_q.ctrl.singleRail && s_q.ctrl.clockDataRecovery
      && !launch && !regWr |=> $stable(rxNegativeRail))
    else $error("violation pin moved off the launch edge");

  launch_edge_a: assert property (s_q.ctrl.clockDataRecovery && !regWr
      && $changed(s_d.rxPositiveRail) |-> launch)
    else $error("receive data changed off the selected edge");

  ais_clock_a: assert property (aisClock |=> rxClockOut == $past(pinLevel[PIN_MCLK]))
    else $error("receive clock not from master clock under LOS");

  rec_clock_a: assert property (!aisClock && s_q.ctrl.clockDataRecovery
      |=> rxClockOut == $past(pinLevel[PIN_RECCLK]))
    else $error("receive clock not the recovered clock");

  bypass_xor_a: assert property (!aisClock && !s_q.ctrl.clockDataRecovery && !regWr
      |=> rxClockOut == $past(inPos ^ inNeg) && rxPositiveRail == ($past(inPos) ^ s_q.ctrl.invertData))
    else $error("bypass clock or data wrong");

  tx_hiz_a: assert property (s_q.mclkLost |=> !txLineOe && !txLinePos && !txLineNeg)
    else $error("line drivers active without master clock");

  mclk_loss_a: assert property ($rose(s_q.mclkLost) |->
      $past(s_q.mclkCnt) == MCLK_LOSS_LIMIT - 6'h01 && !$past(mclkEdge))
    else $error("master clock loss declared at wrong time");

  ones_ref_a: assert property (s_q.ctrl.automaticAllOnesSend && losIn && !s_q.mclkLost
      && !regWr ##1 $changed(txLinePos) && !s_q.mclkLost |-> $past(mclkRise))
    else $error("automatic all ones not timed by master clock");

  miss_cover_c: cover property ($rose(txClockIrq));
  cv_cover_c:   cover property (s_q.ctrl.singleRail && $rose(rxNegativeRail));
  ais_cover_c:  cover property (aisClock ##1 $rose(rxClockOut));
  hiz_cover_c:  cover property ($fell(txLineOe));

endmodule // rx_system_interface

`default_nettype wire

// >>> tb/framer_model.sv
// framer side model: samples the receive rails and counts what it sees
// assumes rising launch, so data is settled at the falling receive edge
`timescale 1ns/1ps
`default_nettype none

module framer_model (
  input  wire logic rxClockOut,
  input  wire logic rxPositiveRail,
  input  wire logic rxNegativeRail,
  output var  int   onesSeen,
  output var  int   flagsSeen
);
  // ==========================================================
  // sampling on the opposite edge avoids a race with the launch
  initial begin
    onesSeen = 0;
    flagsSeen = 0;
  end

  always @(negedge rxClockOut) begin
    onesSeen  <= onesSeen + int'(rxPositiveRail);
    flagsSeen <= flagsSeen + int'(rxNegativeRail);
  end
endmodule // framer_model

`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the receive system interface
// assumes the design package and the framer model are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import rx_sysif_pkg::*;
  logic              clk = 0, resetn = 0, regWr = 0, regRd = 0, losIn = 0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0, regRdData, rd;
  logic              mclkIn = 0, txClockIn = 0, recClockIn = 0;
  logic              rxSlicePos = 0, rxSliceNeg = 0, txPosIn = 0, txNegIn = 0;
  logic              mclkOn = 1, txOn = 1, recOn = 0, pol = 0;
  logic              rxClockOut, rxPositiveRail, rxNegativeRail;
  logic              txLinePos, txLineNeg, txLineOe, txClockIrq;
  logic [31:0]       seed = 32'he1630cf9;
  int                nErrors = 0, totalChecks = 0, onesSeen, flagsSeen;
  int                ones0, flags0, marks, rises, posMarks, txMarks;

  // ==========================================================
  // clocks; foreign clocks run while their enables are set and are unrelated to clk
  always #12.5 clk = ~clk;
  always #244 if (mclkOn) mclkIn <= ~mclkIn;
  always #250 if (txOn) txClockIn <= ~txClockIn;
  always #100 if (recOn) recClockIn <= ~recClockIn;
  always @(posedge rxClockOut) rises++;
  always @(posedge txLinePos) txMarks++;

  rx_system_interface rx_system_interface_i (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .mclkIn(mclkIn),
    .txClockIn(txClockIn), .recClockIn(recClockIn), .rxSlicePos(rxSlicePos),
    .rxSliceNeg(rxSliceNeg), .txPosIn(txPosIn), .txNegIn(txNegIn), .losIn(losIn),
    .rxClockOut(rxClockOut), .rxPositiveRail(rxPositiveRail),
    .rxNegativeRail(rxNegativeRail), .txLinePos(txLinePos), .txLineNeg(txLineNeg),
    .txLineOe(txLineOe), .txClockIrq(txClockIrq));

  framer_model framer_model_i (
    .rxClockOut(rxClockOut), .rxPositiveRail(rxPositiveRail),
    .rxNegativeRail(rxNegativeRail), .onesSeen(onesSeen), .flagsSeen(flagsSeen));

  // ==========================================================
  // helpers: random source, expectations, bus cycles, checks
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // bypass: clock is the rail xor, rails pass through at the chosen polarity
  function automatic logic [2:0] expBypass(input logic p, input logic n, input logic inv);
    return {p ^ n, p ^ inv, n ^ inv};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic regRead(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rd = regRdData;
  endtask

  // one line bit; slicer changes mid bit, away from the sampling edge
  task automatic sendBit(input logic isMark, input logic bipolar_violation);
    @(negedge recClockIn);
    if (isMark && !bipolar_violation) pol = ~pol;
    rxSlicePos <= isMark & pol;
    rxSliceNeg <= isMark & ~pol;
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog; the whole run needs well under half of this
  initial begin
    #500000;
    nErrors++;
    summarize();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    regRead(CTRL_ADDR);
    check(rd, CTRL_RESET);
    regWrite(4'h7, 16'hffff);
    regRead(4'h7);
    check(rd, 16'h0000);
    regRead(CTRL_ADDR);
    check(rd, CTRL_RESET);
    settle(20);
    check(16'(txLineOe), 16'h1);
    // stuck transmit clock: silent before the limit, flagged after it
    txOn = 0;
    repeat (60) @(posedge mclkIn);
    regRead(STATUS_ADDR);
    check(16'(rd[STAT_MISS_NOW]), 16'h0);
    repeat (15) @(posedge mclkIn);
    regRead(STATUS_ADDR);
    check(16'(rd[STAT_MISS_NOW]), 16'h1);
    check(16'(txClockIrq), 16'h0);
    regWrite(CTRL_ADDR, 16'h0019);
    settle(3);
    check(16'(txClockIrq), 16'h1);
    txOn = 1;
    settle(100);
    regWrite(STATUS_ADDR, 16'h0001);
    settle(4);
    regRead(STATUS_ADDR);
    check(16'(rd[1:0]), 16'h0);
    check(16'(txClockIrq), 16'h0);
    // bypass with random slicer and transmit pins
    regWrite(CTRL_ADDR, 16'h0010);
    for (int i = 0; i < 24; i++) begin
      if (i == 12) regWrite(CTRL_ADDR, 16'h0030);
      seed = xorshift(seed);
      @(posedge clk);
      rxSlicePos <= seed[0] | (i == 0);
      rxSliceNeg <= seed[1] | (i == 0);
      txPosIn <= seed[2];
      txNegIn <= seed[3];
      settle(8);
      check(16'({rxClockOut, rxPositiveRail, rxNegativeRail}),
            16'(expBypass(seed[0] | (i == 0), seed[1] | (i == 0), i >= 12)));
      check(16'({txLineOe, txLinePos, txLineNeg}), {13'h0, 1'b1, seed[2], seed[3]});
    end
    // single rail ami with one bipolar violation in a random stream
    @(posedge clk);
    rxSlicePos <= 1'b0;
    rxSliceNeg <= 1'b0;
    regWrite(CTRL_ADDR, 16'h0019);
    recOn = 1;
    repeat (8) sendBit(1'b0, 1'b0);
    sendBit(1'b1, 1'b0);
    repeat (16) sendBit(1'b0, 1'b0);
    ones0 = onesSeen;
    flags0 = flagsSeen;
    marks = 0;
    for (int i = 0; i < 48; i++) begin
      seed = xorshift(seed);
      sendBit(seed[0] | (i == 18) | (i == 19), i == 19);
      marks += int'(seed[0] | (i == 18) | (i == 19));
    end
    repeat (16) sendBit(1'b0, 1'b0);
    check(16'(onesSeen - ones0), 16'(marks));
    check(16'(flagsSeen - flags0), 16'h1);
    // dual rail with recovery: each mark comes out on its own retimed rail
    regWrite(CTRL_ADDR, 16'h0018);
    repeat (4) sendBit(1'b0, 1'b0);
    ones0 = onesSeen;
    flags0 = flagsSeen;
    marks = 0;
    posMarks = 0;
    for (int i = 0; i < 24; i++) begin
      seed = xorshift(seed);
      sendBit(seed[0], 1'b0);
      marks += int'(seed[0]);
      posMarks += int'(seed[0] & pol);
    end
    repeat (4) sendBit(1'b0, 1'b0);
    check(16'(onesSeen - ones0), 16'(posMarks));
    check(16'(flagsSeen - flags0), 16'(marks - posMarks));
    // loss of signal with alarm enable: clock taken from master
    recOn = 0;
    regWrite(CTRL_ADDR, 16'h0859);  // automatic all ones armed as well
    losIn <= 1'b1;
    regRead(STATUS_ADDR);
    check(16'(rd[STAT_LOS]), 16'h1);
    rises = 0;
    txMarks = 0;
    settle(400);
    check(16'(rises >= 19 && rises <= 22), 16'h1);
    check(16'(txMarks >= 9 && txMarks <= 11), 16'h1);
    @(posedge clk);
    losIn <= 1'b0;
    settle(10);
    rises = 0;
    settle(400);
    check(16'(rises), 16'h0);
    // patterns on the master reference keep running with the transmit clock stopped
    txOn = 0;
    regWrite(CTRL_ADDR, 16'h0280);
    txMarks = 0;
    settle(400);
    check(16'(txMarks >= 9 && txMarks <= 11), 16'h1);
    regWrite(CTRL_ADDR, 16'h0300);
    txMarks = 0;
    settle(400);
    check(16'(txMarks >= 9 && txMarks <= 11), 16'h1);
    txOn = 1;
    // master clock lost: drivers released, then back on restart
    mclkOn = 0;
    settle(60);
    check(16'({txLineOe, txLinePos, txLineNeg}), 16'h0);
    regRead(STATUS_ADDR);
    check(16'(rd[STAT_MCLK_LOST]), 16'h1);
    mclkOn = 1;
    settle(40);
    check(16'(txLineOe), 16'h1);
    summarize();
  end
endmodule // tb_top

`default_nettype wire
